// ===== capture_compare_pkg.sv
/*
  Constants shared by the 16-bit capture/compare timer: register indices,
  field positions, codes of the clock, action and edge selections, and
  reset values.
  Assumes a 16-bit register port with word addresses and a 10 MHz clock.
*/
`default_nettype none
package capture_compare_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CHANNELS = 4;

  // Register indices on the word-addressed register port.
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CHANNEL_CFG = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_COUNT = 4'h3;
  localparam logic [3:0] ADDR_GENERAL_A = 4'h4;
  localparam logic [3:0] ADDR_GENERAL_D = 4'h7;
  localparam logic [3:0] ADDR_OUT_LEVEL = 4'h8;

  // Control register fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLK_LO = 1;
  localparam int CTRL_CLK_HI = 3;
  localparam int CTRL_PWM = 4;
  localparam int CTRL_CLR_LO = 5;
  localparam int CTRL_CLR_HI = 7;
  localparam int CTRL_BUF_LO = 8;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // Clock source codes.
  localparam logic [2:0] CLK_DIV1 = 3'h0;
  localparam logic [2:0] CLK_DIV2 = 3'h1;
  localparam logic [2:0] CLK_DIV4 = 3'h2;
  localparam logic [2:0] CLK_DIV8 = 3'h3;
  localparam logic [2:0] CLK_EXT = 3'h4;

  // Clear source code zero means no clearing; code n clears on match of register n-1.
  localparam logic [2:0] CLR_NONE = 3'h0;

  // Per channel configuration: four bits each.
  localparam int CFG_BITS = 4;
  localparam int CFG_SEL_LO = 0;
  localparam int CFG_CAPTURE = 2;
  localparam logic [15:0] CHANNEL_CFG_RESET = 16'h0000;

  // Compare action codes and capture edge bits share the two select bits.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam int EDGE_RISE = 0;
  localparam int EDGE_FALL = 1;

  // Status layout: wrap flag, three reserved ones, flags D to A.
  localparam int STAT_WRAP = 7;
  localparam int STAT_RSV_LO = 4;
  localparam logic [2:0] STAT_RSV_VALUE = 3'h7;
  localparam int FLAGS = 5;
  localparam int FLAG_WRAP = 4;

  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] GENERAL_RESET = 16'hffff;

endpackage : capture_compare_pkg
`default_nettype wire

// ===== capture_compare_timer.sv
/*
  Sixteen-bit capture/compare timer with four general registers, buffering
  pairs, compare-driven outputs, edge-selected capture, clear on match, PWM
  and five request flags.
  Assumes one 10 MHz clock, a register port of one-cycle strobes, and timer
  pins that are asynchronous to the clock.
*/
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Sixteen-bit counter compared or captured per register.
// - Five clock sources: divide 1,2,4,8, external.
// - External source counts pin events.
// - Each register chooses compare or capture.
// - Two pairs; one register buffers its partner.
// - Compare match drives low, high or toggle.
// - Capture on rising, falling or both edges.
// - Counter clears on selected compare match.
// - PWM mode drives up to three outputs.
// - Software presets output levels before counting.
// - Five requests: four channels plus overflow.
// - Wrap flag in bit seven on overflow.
// - Flags clear by read-one then write-zero.
// - Flag D on match or capture of D.
// - Flag C on match or capture of C.
// - Status bits six to four read one.
module capture_compare_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic                                      CLK,
  input  wire logic                                      NRST,
  // Register port
  input  wire logic [capture_compare_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic [capture_compare_pkg::DATA_W-1:0]    WDATA,
  input  wire logic                                      WR,
  input  wire logic                                      RD,
  output var  logic [capture_compare_pkg::DATA_W-1:0]    RDATA,
  // Timer pins
  input  wire logic                                      EVENT_CLK,
  input  wire logic [capture_compare_pkg::CHANNELS-1:0]  CAPTURE_IN,
  output var  logic [capture_compare_pkg::CHANNELS-1:0]  COMPARE_OUT,
  output var  logic [capture_compare_pkg::CHANNELS-1:0]  COMPARE_OE,
  // Request lines, one per flag
  output var  logic [capture_compare_pkg::FLAGS-1:0]     REQUEST
);

  localparam int N = capture_compare_pkg::CHANNELS;

  typedef struct packed {
    logic [WIDTH-1:0]                         count_value;
    logic [N-1:0][WIDTH-1:0]                  general;
    logic [15:0]                              control;
    logic [15:0]                              channel_cfg;
    logic [capture_compare_pkg::FLAGS-1:0]    flag;
    logic [capture_compare_pkg::FLAGS-1:0]    armed;
    logic [N-1:0]                             level;
    logic [N-1:0]                             drive;
    logic [2:0]                               prescale;
    logic                                     event_s1;
    logic                                     event_s2;
    logic                                     event_last;
    logic [N-1:0]                             capture_s1;
    logic [N-1:0]                             capture_s2;
    logic [N-1:0]                             capture_last;
    logic [capture_compare_pkg::DATA_W-1:0]   rdata;
  } state_type;

  state_type s;
  state_type next_s;

  assign RDATA = s.rdata;
  assign COMPARE_OUT = s.level;
  assign COMPARE_OE = s.drive;
  assign REQUEST = s.flag;

  always_comb begin
    logic                             run;
    logic [2:0]                       clk_sel;
    logic [2:0]                       clr_sel;
    logic                             pwm;
    logic                             tick;
    logic [N-1:0]                     is_capture;
    logic [N-1:0]                     is_buffer;
    logic [N-1:0]                     match;
    logic [N-1:0]                     captured;
    logic [N-1:0]                     rise;
    logic [N-1:0]                     fall;
    logic [1:0]                       sel;
    logic                             clear_hit;
    logic [capture_compare_pkg::FLAGS-1:0] set_flag;
    logic [7:0]                       status_view;
    logic [3:0]                       gidx;
    next_s = s;
    run = s.control[capture_compare_pkg::CTRL_RUN];
    clk_sel = s.control[capture_compare_pkg::CTRL_CLK_HI:capture_compare_pkg::CTRL_CLK_LO];
    clr_sel = s.control[capture_compare_pkg::CTRL_CLR_HI:capture_compare_pkg::CTRL_CLR_LO];
    pwm = s.control[capture_compare_pkg::CTRL_PWM];
    is_capture = '0;
    is_buffer = '0;
    match = '0;
    captured = '0;
    set_flag = '0;
    sel = capture_compare_pkg::ACT_NONE;
    clear_hit = 1'b0;
    gidx = 4'h0;

    // Pins pass two flops; edges are taken from the second stage only.
    next_s.event_s1 = EVENT_CLK;
    next_s.event_s2 = s.event_s1;
    next_s.event_last = s.event_s2;
    next_s.capture_s1 = CAPTURE_IN;
    next_s.capture_s2 = s.capture_s1;
    next_s.capture_last = s.capture_s2;
    rise = s.capture_s2 & ~s.capture_last;
    fall = ~s.capture_s2 & s.capture_last;

    // Prescaler runs freely so that a source change takes effect at once.
    next_s.prescale = s.prescale + 3'h1;
    unique case (clk_sel)
      capture_compare_pkg::CLK_DIV1: tick = 1'b1;
      capture_compare_pkg::CLK_DIV2: tick = s.prescale[0];
      capture_compare_pkg::CLK_DIV4: tick = &s.prescale[1:0];
      capture_compare_pkg::CLK_DIV8: tick = &s.prescale;
      capture_compare_pkg::CLK_EXT:  tick = s.event_s2 & ~s.event_last;
      default:                       tick = 1'b0;
    endcase
    tick = tick & run;

    for (int i = 0; i < N; i++) begin
      is_capture[i] = s.channel_cfg[i*capture_compare_pkg::CFG_BITS + capture_compare_pkg::CFG_CAPTURE];
    end
    for (int p = 0; p < N/2; p++) begin
      is_buffer[p+N/2] = s.control[capture_compare_pkg::CTRL_BUF_LO + p];
    end

    for (int i = 0; i < N; i++) begin
      sel = s.channel_cfg[i*capture_compare_pkg::CFG_BITS + capture_compare_pkg::CFG_SEL_LO +: 2];
      if (!is_buffer[i]) begin
        if (is_capture[i]) begin
          captured[i] = (sel[capture_compare_pkg::EDGE_RISE] & rise[i])
                      | (sel[capture_compare_pkg::EDGE_FALL] & fall[i]);
        end else begin
          match[i] = tick && (s.count_value == s.general[i]);
        end
      end
    end

    // Compare outputs; PWM mode takes channels B to D over.
    for (int i = 0; i < N; i++) begin
      sel = s.channel_cfg[i*capture_compare_pkg::CFG_BITS + capture_compare_pkg::CFG_SEL_LO +: 2];
      next_s.drive[i] = ~is_capture[i] & ~is_buffer[i];
      if (pwm && i > 0) begin
        if (match[0]) begin
          next_s.level[i] = 1'b1;
        end
        if (match[i]) begin
          next_s.level[i] = 1'b0;
        end
      end else if (match[i]) begin
        unique case (sel)
          capture_compare_pkg::ACT_NONE:   next_s.level[i] = s.level[i];
          capture_compare_pkg::ACT_LOW:    next_s.level[i] = 1'b0;
          capture_compare_pkg::ACT_HIGH:   next_s.level[i] = 1'b1;
          capture_compare_pkg::ACT_TOGGLE: next_s.level[i] = ~s.level[i];
        endcase
      end
    end

    // Counter: clear on the selected match, else count.
    for (int i = 0; i < N; i++) begin
      if (clr_sel == 3'(i + 1) && match[i]) begin
        clear_hit = 1'b1;
      end
    end
    if (tick) begin
      next_s.count_value = clear_hit ? WIDTH'(capture_compare_pkg::COUNT_ZERO)
                                     : s.count_value + WIDTH'(1);
    end
    set_flag[capture_compare_pkg::FLAG_WRAP] = tick && !clear_hit
        && (s.count_value == WIDTH'(capture_compare_pkg::COUNT_MAX));

    // Capture and buffer transfers.
    for (int p = 0; p < N/2; p++) begin
      if (is_buffer[p+N/2] && match[p]) begin
        next_s.general[p] = s.general[p+N/2];
      end
    end
    for (int i = 0; i < N; i++) begin
      if (captured[i]) begin
        next_s.general[i] = s.count_value;
        if (i < N/2 && is_buffer[i+N/2]) begin
          next_s.general[(i+N/2)%N] = s.general[i];
        end
      end
    end
    set_flag[N-1:0] = match | captured;

    // Register port.
    status_view = {s.flag[capture_compare_pkg::FLAG_WRAP], capture_compare_pkg::STAT_RSV_VALUE,
                   s.flag[N-1:0]};
    next_s.rdata = '0;
    if (RD) begin
      gidx = ADDR - capture_compare_pkg::ADDR_GENERAL_A;
      if (ADDR == capture_compare_pkg::ADDR_CONTROL) begin
        next_s.rdata = s.control;
      end else if (ADDR == capture_compare_pkg::ADDR_CHANNEL_CFG) begin
        next_s.rdata = s.channel_cfg;
      end else if (ADDR == capture_compare_pkg::ADDR_STATUS) begin
        next_s.rdata = {8'h00, status_view};
        next_s.armed = s.armed | s.flag;
      end else if (ADDR == capture_compare_pkg::ADDR_COUNT) begin
        next_s.rdata = 16'(s.count_value);
      end else if (ADDR >= capture_compare_pkg::ADDR_GENERAL_A
                   && ADDR <= capture_compare_pkg::ADDR_GENERAL_D) begin
        next_s.rdata = 16'(s.general[gidx[1:0]]);
      end else if (ADDR == capture_compare_pkg::ADDR_OUT_LEVEL) begin
        next_s.rdata = {12'h000, s.level};
      end
    end
    if (WR) begin
      gidx = ADDR - capture_compare_pkg::ADDR_GENERAL_A;
      if (ADDR == capture_compare_pkg::ADDR_CONTROL) begin
        next_s.control = WDATA;
      end else if (ADDR == capture_compare_pkg::ADDR_CHANNEL_CFG) begin
        next_s.channel_cfg = WDATA;
      end else if (ADDR == capture_compare_pkg::ADDR_STATUS) begin
        // Only a flag seen as one by an earlier read may be cleared by a zero.
        for (int f = 0; f < capture_compare_pkg::FLAGS; f++) begin
          if (s.armed[f] && !WDATA[f == capture_compare_pkg::FLAG_WRAP ? capture_compare_pkg::STAT_WRAP : f]) begin
            next_s.flag[f] = 1'b0;
          end
        end
        next_s.armed = '0;
      end else if (ADDR == capture_compare_pkg::ADDR_COUNT) begin
        next_s.count_value = WIDTH'(WDATA);
      end else if (ADDR >= capture_compare_pkg::ADDR_GENERAL_A
                   && ADDR <= capture_compare_pkg::ADDR_GENERAL_D) begin
        next_s.general[gidx[1:0]] = WIDTH'(WDATA);
      end else if (ADDR == capture_compare_pkg::ADDR_OUT_LEVEL) begin
        next_s.level = WDATA[N-1:0];
      end
    end
    // A hardware event in the clearing cycle wins over the clear.
    next_s.flag = next_s.flag | set_flag;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
      s.control <= capture_compare_pkg::CONTROL_RESET;
      s.channel_cfg <= capture_compare_pkg::CHANNEL_CFG_RESET;
      s.general <= {N{WIDTH'(capture_compare_pkg::GENERAL_RESET)}};
    end else begin
      s <= next_s;
    end
  end

endmodule : capture_compare_timer
`default_nettype wire

// ===== capture_compare_pins.sv
/* Timer pin model: external event clock and capture pins.
   Assumes the bench calls its tasks; pins move just after CLK edges. */
`timescale 1ns/1ns
`default_nettype none
module capture_compare_pins (
  // Clock
  input  wire logic       CLK,
  // Pins
  output var  logic       EVENT_CLK,
  output var  logic [3:0] CAPTURE_IN
);
  initial begin
    EVENT_CLK  = 1'b0;
    CAPTURE_IN = 4'h0;
  end
  // Each level is held at least two clocks so the two-flop synchroniser cannot miss it.
  task automatic events(input int n);
    repeat (n) begin
      @(posedge CLK) EVENT_CLK <= 1'b1;
      repeat (2) @(posedge CLK);
      EVENT_CLK <= 1'b0;
      repeat (2) @(posedge CLK);
    end
  endtask : events
  task automatic set_d(input logic v);
    @(posedge CLK) CAPTURE_IN[3] <= v;
    repeat (6) @(posedge CLK);
  endtask : set_d
endmodule : capture_compare_pins
`default_nettype wire

// ===== capture_compare_timer_assertions.sv
/* Port checker for the capture/compare timer.
   Assumes one clock domain and the register map of the package. */
`timescale 1ns/1ns
`default_nettype none
module capture_compare_timer_assertions (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // Register port
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  // Pins and requests
  input wire logic [3:0]  COMPARE_OUT,
  input wire logic [3:0]  COMPARE_OE,
  input wire logic [4:0]  REQUEST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic st_rd;
  assign st_rd = RD && ADDR == 4'h2;

  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
    else $error("read data not zero");
  a_rsv_ones: assert property (st_rd |=> RDATA[15:8] == 8'h00 && RDATA[6:4] == 3'h7)
    else $error("reserved status bits wrong");
  a_wrap_mirror: assert property (st_rd |=> RDATA[7] == $past(REQUEST[4]))
    else $error("wrap flag read wrong");
  a_flag_mirror: assert property (st_rd |=> RDATA[3:0] == $past(REQUEST[3:0]))
    else $error("channel flags read wrong");
  a_flag_hold: assert property (|($past(REQUEST) & ~REQUEST) |-> $past(WR && ADDR == 4'h2))
    else $error("flag fell without status write");
  a_clear_zero: assert property (!(|($past(REQUEST) & ~REQUEST & {$past(WDATA[7]), $past(WDATA[3:0])})))
    else $error("flag cleared by a one");
  a_oe_capture: assert property (WR && ADDR == 4'h1 && WDATA[14] |-> ##[1:2] !COMPARE_OE[3])
    else $error("capture channel drives its pin");
  a_out_preset: assert property (WR && ADDR == 4'h8 |=> COMPARE_OUT == $past(WDATA[3:0]))
    else $error("preset level not applied");
  a_unmapped_zero: assert property (RD && ADDR > 4'h8 |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");

  c_flag_a: cover property ($rose(REQUEST[0]));
  c_wrap: cover property ($rose(REQUEST[4]));
  c_flag_d: cover property ($rose(REQUEST[3]));
endmodule : capture_compare_timer_assertions
bind capture_compare_timer capture_compare_timer_assertions u_chk (
  .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .COMPARE_OUT(COMPARE_OUT), .COMPARE_OE(COMPARE_OE), .REQUEST(REQUEST));
`default_nettype wire

// ===== sixteen_bit_capture_compare_timer_test.sv
/* Self-checking bench for the capture/compare timer.
   Assumes the pin model capture_compare_pins and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module sixteen_bit_capture_compare_timer_test;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [15:0] RDATA, r;
  logic        EVENT_CLK;
  logic [3:0]  CAPTURE_IN, COMPARE_OUT, COMPARE_OE;
  logic [4:0]  REQUEST;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;

  always #50 CLK = ~CLK;

  capture_compare_timer #(.WIDTH(16)) u_dut (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EVENT_CLK(EVENT_CLK), .CAPTURE_IN(CAPTURE_IN), .COMPARE_OUT(COMPARE_OUT),
    .COMPARE_OE(COMPARE_OE), .REQUEST(REQUEST));
  capture_compare_pins u_pins (.CLK(CLK), .EVENT_CLK(EVENT_CLK), .CAPTURE_IN(CAPTURE_IN));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 r = RDATA;
  endtask : rd
  task automatic end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic t_reset;
    rd(4'h2);
    chk(r, 16'h0070);
    for (int a = 4; a < 8; a++) begin
      rd(4'(a));
      chk(r, 16'hffff);
    end
    rd(4'hf);
    chk(r, 16'h0000);
    chk({12'h0, COMPARE_OE}, 16'h000f);
    $display("test reset done");
  endtask : t_reset

  // A toggles at 3, C goes high at 5, D goes low at 7 from preset 4'h8.
  task automatic t_compare;
    wr(4'h8, 16'h0008);
    wr(4'h4, 16'h0003);
    wr(4'h6, 16'h0005);
    wr(4'h7, 16'h0007);
    wr(4'h1, 16'h1203);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0001);
    for (int i = 0; i < 100 && REQUEST[3] !== 1'b1; i++) @(posedge CLK);
    wr(4'h0, 16'h0000);
    chk({12'h0, COMPARE_OUT}, 16'h0005);
    chk({11'h0, REQUEST}, 16'h000d);
    wr(4'h2, 16'h0000);
    rd(4'h2);
    chk(r, 16'h007d);
    wr(4'h2, 16'h0000);
    rd(4'h2);
    chk(r, 16'h0070);
    $display("test compare done");
  endtask : t_compare

  task automatic t_wrap_clear;
    wr(4'h3, 16'hfffc);
    wr(4'h0, 16'h0001);
    repeat (10) @(posedge CLK);
    wr(4'h0, 16'h0000);
    rd(4'h2);
    chk({15'h0, r[7]}, 16'h0001);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0021);
    repeat (40) @(posedge CLK);
    wr(4'h0, 16'h0000);
    rd(4'h3);
    chk({15'h0, r <= 16'h0003}, 16'h0001);
    $display("test wrap and clear done");
  endtask : t_wrap_clear

  task automatic t_clock;
    for (int c = 0; c < 4; c++) begin
      wr(4'h3, 16'h0000);
      wr(4'h0, 16'(2 * c + 1));
      repeat (32) @(posedge CLK);
      wr(4'h0, 16'h0000);
      rd(4'h3);
      chk({15'h0, r + 2 >= (34 >> c) && r <= (34 >> c) + 2}, 16'h0001);
    end
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0009);
    u_pins.events(5);
    repeat (6) @(posedge CLK);
    wr(4'h0, 16'h0000);
    rd(4'h3);
    chk(r, 16'h0005);
    $display("test clock done");
  endtask : t_clock

  // Steps: capture edge code of D, pin level, count, expected D.
  task automatic t_capture;
    logic [3:0]  cf[5] = '{4'h5, 4'h5, 4'h6, 4'h6, 4'h7};
    logic        lv[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] cn[5] = '{16'h1234, 16'h5678, 16'h9abc, 16'h4321, 16'h1111};
    logic [15:0] ex[5] = '{16'h1234, 16'h1234, 16'h1234, 16'h4321, 16'h1111};
    rd(4'h2);
    wr(4'h2, 16'h0000);
    for (int s = 0; s < 5; s++) begin
      wr(4'h1, {cf[s], 12'h000});
      wr(4'h3, cn[s]);
      u_pins.set_d(lv[s]);
      rd(4'h7);
      chk(r, ex[s]);
      if (s == 0) chk({15'h0, REQUEST[3]}, 16'h0001);
    end
    $display("test capture done");
  endtask : t_capture

  // PWM: B rises on the period match of A at 9; B falls at 6, far from the stop.
  // Buffer: C holds the next value of A, loaded on the match of A at 5.
  task automatic t_pwm_buffer;
    rd(4'h2);
    wr(4'h2, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h8, 16'h0000);
    wr(4'h4, 16'h0009);
    wr(4'h5, 16'h0006);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0031);
    for (int i = 0; i < 100 && REQUEST[0] !== 1'b1; i++) @(posedge CLK);
    wr(4'h0, 16'h0000);
    chk({15'h0, COMPARE_OUT[1]}, 16'h0001);
    rd(4'h2);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0005);
    wr(4'h6, 16'h0020);
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0101);
    for (int i = 0; i < 100 && REQUEST[0] !== 1'b1; i++) @(posedge CLK);
    wr(4'h0, 16'h0000);
    rd(4'h4);
    chk(r, 16'h0020);
    $display("test pwm and buffer done");
  endtask : t_pwm_buffer

  initial begin
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    t_compare();
    t_wrap_clear();
    t_clock();
    t_capture();
    t_pwm_buffer();
    end_sim();
  end

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
endmodule : sixteen_bit_capture_compare_timer_test
`default_nettype wire
